// ===== rtl/shm_host_access.sv
// Shared memory host access sequencer, address mux, counters and write gating
// Behaviour
// R1: Sequencer is clocked by system clock; host inputs pass a two-stage synchroniser.
// R2: Memory transactions take about six clocks; shift commands about seventy.
// R3: Processor keeps running and owning buses while host selection is captured.
// R4: First command cycle stops processor clock, swaps bus buffers to host.
// R5: Host holds its transaction while ready is inactive.
// R6: After ready, host deselects; captured deselection returns sequencer to idle.
// R7: On idle return, host path off, processor clock on, buses to processor.
// R8: Memory outputs are disabled whenever write enable is active.
// R9: Write enable steers host transceiver direction and processor write-data buffer together.
// R10: Memory chip enable is off when nobody selects the memory.
// R11: Write strobe is gated with the system clock, high early in cycle; code only registers memory_write_phase from write enable, no clock gating.
// R12: Exactly one of four address sources drives the memory address bus.
// R13: Each address counter is loadable and counts up or down.
// R14: Each counter is two cascaded seven-bit halves forming fourteen bits.
// R15: Counters load only from the register-file address bus.
// R16: Memory holds 16K words of 36 bits.
// R17: Processor read completes in one cycle; data ready next cycle.
// R18: Read data returns on the register file second write port.
// R19: Processor write takes address and data from both read ports at once.
// R20: Host selects memory with host address bits 17 and 16 low.
// R21: Word address comes from source bits 2 through 15.
// R22: Host access drops processor path then raises host path.
// R23: Idle host leaves processor path enabled and host path disabled.
`include "shm_cfg.svh"

module shm_addr_counter_half
    import shm_pkg::*;
#(
    parameter int W = `SHM_HALF_W
) (
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire shm_cnt_op_t   op,
    input  wire logic          carry_in,
    input  wire logic [W-1:0]  load_value,
    output logic      [W-1:0]  count,
    output logic               carry_out
);
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    wire          all_ones  = &count_reg;
    wire          all_zeros = ~|count_reg;

    assign carry_out  = (op == SHM_CNT_UP) ? (carry_in & all_ones)
                      : (op == SHM_CNT_DOWN) ? (carry_in & all_zeros) : 1'b0;
    assign count_next = (op == SHM_CNT_LOAD) ? load_value                 // R13
                      : (op == SHM_CNT_UP && carry_in) ? count_reg + 1'b1
                      : (op == SHM_CNT_DOWN && carry_in) ? count_reg - 1'b1
                      : count_reg;
    assign count      = count_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule

module shm_host_access
    import shm_pkg::*;
#(
    parameter int ADDR_W        = `SHM_ADDR_W,
    parameter int DATA_W        = `SHM_DATA_W,
    parameter int ACCESS_CYCLES = `SHM_MEM_ACCESS_CYC
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire shm_cpu_ctl_t          cpu_ctl,
    input  wire logic [31:0]           regfile_port_a,
    input  wire logic [DATA_W-1:0]     regfile_port_b,
    input  wire shm_host_req_t         host_req,
    input  wire logic [DATA_W-1:0]     host_wdata,
    input  wire logic [DATA_W-1:0]     memory_rdata,
    output logic [DATA_W-1:0]          regfile_write_b_data,
    output logic                       regfile_write_b_en,
    output logic [DATA_W-1:0]          host_rdata,
    output logic                       host_rdata_oe,
    output logic                       host_ready,
    output logic                       cpu_clock_run,
    output logic                       cpu_path_enable_n,
    output logic                       host_path_enable_n,
    output logic [ADDR_W-1:0]          memory_address_bus,
    output logic [DATA_W-1:0]          memory_data_bus,
    output logic                       memory_data_oe,
    output logic                       memory_chip_enable_n,
    output logic                       memory_output_enable_n,
    output logic                       memory_write_enable_n,
    output logic                       memory_write_phase
);
    typedef enum logic [2:0] {IDLE, GRAB, ACCESS, READY, RELEASE} shm_seq_t;

    // Array geometry and wait counter range
    if (ADDR_W != 2 * `SHM_HALF_W || DATA_W != `SHM_DATA_W) begin : g_geometry_check // R16
        $error("shm_host_access: unsupported memory geometry");
    end
    if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 16) begin : g_wait_check
        $error("shm_host_access: unsupported access cycle count");
    end

    // Host synchroniser (R1)
    shm_host_req_t     sync1_reg;
    shm_host_req_t     sync2_reg;
    logic [DATA_W-1:0] wdata_sync1_reg;
    logic [DATA_W-1:0] wdata_sync2_reg;
    shm_seq_t          state_reg;
    shm_seq_t          state_next;
    logic [3:0]        wait_reg;
    logic [3:0]        wait_next;
    logic              host_write_reg;
    logic [ADDR_W-1:0] host_addr_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_reg       <= '0;
            sync2_reg       <= '0;
            wdata_sync1_reg <= '0;
            wdata_sync2_reg <= '0;
        end else begin
            sync1_reg       <= host_req;         // R1
            sync2_reg       <= sync1_reg;        // R1
            wdata_sync1_reg <= host_wdata;       // R1
            wdata_sync2_reg <= wdata_sync1_reg;  // R1
        end
    end

    wire host_mem_sel = sync2_reg.select &&
        (sync2_reg.addr[`SHM_SEL_MSB:`SHM_SEL_LSB] == `SHM_SEL_MEM); // R20

    // Sequencer
    always_comb begin
        state_next = state_reg;
        wait_next  = wait_reg;
        case (state_reg)
            IDLE: begin
                if (host_mem_sel) begin
                    state_next = GRAB; // R3
                end
            end
            GRAB: begin
                state_next = ACCESS; // R4
                wait_next  = 4'(ACCESS_CYCLES - 1);
            end
            ACCESS: begin
                if (wait_reg == 4'h0) begin
                    state_next = READY; // R2
                end else begin
                    wait_next = wait_reg - 4'h1;
                end
            end
            READY: begin
                if (!sync2_reg.select) begin
                    state_next = RELEASE; // R6
                end
            end
            RELEASE: begin
                state_next = IDLE; // R7
            end
            default: state_next = IDLE;
        endcase
    end

    wire host_owns  = (state_next == ACCESS) || (state_next == READY);  // R22
    wire grab_next  = (state_next == GRAB) || host_owns;
    wire mem_write_host = host_owns && host_write_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= IDLE;
            wait_reg  <= 4'h0;
        end else begin
            state_reg <= state_next;
            wait_reg  <= wait_next;
        end
    end

    // Host command held from the selecting address
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            host_write_reg <= 1'b0;
            host_addr_reg  <= '0;
        end else if (state_reg == IDLE) begin
            host_write_reg <= sync2_reg.write;
            host_addr_reg  <= sync2_reg.addr[`SHM_WORD_MSB:`SHM_WORD_LSB]; // R21
        end
    end

    // Handshake and bus ownership
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            host_ready         <= 1'b0;
            cpu_clock_run      <= 1'b1;
            cpu_path_enable_n  <= 1'b0;
            host_path_enable_n <= 1'b1;
        end else begin
            host_ready         <= (state_next == READY);   // R5
            cpu_clock_run      <= !grab_next;              // R4 R7
            cpu_path_enable_n  <= grab_next;               // R22 R23
            host_path_enable_n <= !host_owns;              // R22 R23 R7
        end
    end

    // Address counters built from cascaded halves (R14)
    wire  [ADDR_W-1:0] cnt_a;
    wire  [ADDR_W-1:0] cnt_b;
    logic              ca_lo;
    logic              cb_lo;
    logic              read_pending_reg;
    wire  [ADDR_W-1:0] load_src = regfile_port_a[`SHM_WORD_MSB:`SHM_WORD_LSB]; // R15 R21
    wire  [`SHM_HALF_W-1:0] load_lo = load_src[`SHM_HALF_W-1:0];
    wire  [`SHM_HALF_W-1:0] load_hi = load_src[ADDR_W-1:`SHM_HALF_W];
    wire  shm_cnt_op_t op_a = cpu_clock_run ? cpu_ctl.cnt_a_op : SHM_CNT_HOLD;
    wire  shm_cnt_op_t op_b = cpu_clock_run ? cpu_ctl.cnt_b_op : SHM_CNT_HOLD;

    shm_addr_counter_half u_a_lo (
        .clock      (clock),
        .rst        (rst),
        .op         (op_a),
        .carry_in   (1'b1),
        .load_value (load_lo),
        .count      (cnt_a[`SHM_HALF_W-1:0]),
        .carry_out  (ca_lo)
    ); // R14
    shm_addr_counter_half u_a_hi (
        .clock      (clock),
        .rst        (rst),
        .op         (op_a),
        .carry_in   (ca_lo),
        .load_value (load_hi),
        .count      (cnt_a[ADDR_W-1:`SHM_HALF_W]),
        .carry_out  ()
    ); // R14
    shm_addr_counter_half u_b_lo (
        .clock      (clock),
        .rst        (rst),
        .op         (op_b),
        .carry_in   (1'b1),
        .load_value (load_lo),
        .count      (cnt_b[`SHM_HALF_W-1:0]),
        .carry_out  (cb_lo)
    ); // R14
    shm_addr_counter_half u_b_hi (
        .clock      (clock),
        .rst        (rst),
        .op         (op_b),
        .carry_in   (cb_lo),
        .load_value (load_hi),
        .count      (cnt_b[ADDR_W-1:`SHM_HALF_W]),
        .carry_out  ()
    ); // R14

    // Four-way address source selection (R12)
    wire shm_src_t src = host_owns ? SHM_SRC_HOST : cpu_ctl.addr_src;
    wire [ADDR_W-1:0] addr_next = (src == SHM_SRC_HOST)  ? host_addr_reg   // R12
                                : (src == SHM_SRC_CNT_A) ? cnt_a
                                : (src == SHM_SRC_CNT_B) ? cnt_b
                                : load_src;
    wire cpu_access = cpu_clock_run && cpu_ctl.mem_select;              // R3
    wire sel_next   = cpu_access || host_owns;                          // R10
    wire we_next    = host_owns ? mem_write_host : (cpu_access && cpu_ctl.mem_write); // R19
    wire [DATA_W-1:0] wdata_next = host_owns ? wdata_sync2_reg : regfile_port_b; // R19

    // Memory pins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            memory_address_bus     <= '0;
            memory_data_bus        <= '0;
            memory_data_oe         <= 1'b0;
            memory_chip_enable_n   <= 1'b1;
            memory_output_enable_n <= 1'b1;
            memory_write_enable_n  <= 1'b1;
        end else begin
            memory_address_bus     <= addr_next;
            memory_data_bus        <= wdata_next;
            memory_data_oe         <= we_next;               // R9
            memory_chip_enable_n   <= !sel_next;             // R10
            memory_output_enable_n <= we_next || !sel_next;  // R8
            memory_write_enable_n  <= !we_next;
        end
    end

    // Read return, one cycle behind the memory pins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            read_pending_reg     <= 1'b0;
            regfile_write_b_en   <= 1'b0;
            regfile_write_b_data <= '0;
            host_rdata           <= '0;
            host_rdata_oe        <= 1'b0;
        end else begin
            read_pending_reg     <= cpu_access && !cpu_ctl.mem_write;  // R17
            regfile_write_b_en   <= read_pending_reg;                  // R17 R18
            regfile_write_b_data <= memory_rdata;                      // R18
            host_rdata           <= memory_rdata;
            host_rdata_oe        <= host_owns && !mem_write_host;      // R9
        end
    end

    // Write phase marker; the board gates the strobe with the late clock half
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            memory_write_phase <= 1'b0;
        end else begin
            memory_write_phase <= we_next; // R11
        end
    end
endmodule

// ===== rtl/shm_cfg.svh
// Constants for the shared memory host access block
`ifndef SHM_CFG_SVH
`define SHM_CFG_SVH
`define SHM_ADDR_W        14
`define SHM_DATA_W        36
`define SHM_HALF_W        7
`define SHM_HOST_ADDR_W   18
`define SHM_WORD_LSB      2
`define SHM_WORD_MSB      15
`define SHM_SEL_MSB       17
`define SHM_SEL_LSB       16
`define SHM_SEL_MEM       2'h0
`define SHM_MEM_ACCESS_CYC 2
`define SHM_SHIFT_CYC     70
`endif

// ===== rtl/shm_pkg.sv
// Types for the shared memory host access block
package shm_pkg;
    typedef enum logic [1:0] {
        SHM_SRC_REGFILE,
        SHM_SRC_HOST,
        SHM_SRC_CNT_A,
        SHM_SRC_CNT_B
    } shm_src_t;

    typedef enum logic [1:0] {
        SHM_CNT_HOLD,
        SHM_CNT_LOAD,
        SHM_CNT_UP,
        SHM_CNT_DOWN
    } shm_cnt_op_t;

    typedef struct packed {
        logic        mem_select;
        logic        mem_write;
        shm_src_t    addr_src;
        shm_cnt_op_t cnt_a_op;
        shm_cnt_op_t cnt_b_op;
    } shm_cpu_ctl_t;

    typedef struct packed {
        logic        select;
        logic        write;
        logic [17:0] addr;
    } shm_host_req_t;
endpackage

// ===== verif/shm_host_access_properties.sv
// Port checker for the shared memory host access block
module shm_host_access_properties
    import shm_pkg::*;
#(
    parameter int ACCESS_CYCLES = 2
) (
    input wire logic          clock,
    input wire logic          rst,
    input wire shm_cpu_ctl_t  cpu_ctl,
    input wire shm_host_req_t host_req,
    input wire logic          host_ready,
    input wire logic          cpu_clock_run,
    input wire logic          cpu_path_enable_n,
    input wire logic          host_path_enable_n,
    input wire logic          memory_chip_enable_n,
    input wire logic          memory_output_enable_n,
    input wire logic          memory_write_enable_n,
    input wire logic          regfile_write_b_en
);
    localparam int RDY_MIN = ACCESS_CYCLES + 2;
    localparam int RDY_MAX = ACCESS_CYCLES + 7;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence s_keep;
        cpu_clock_run [*2];
    endsequence
    sequence s_restore;
        host_path_enable_n ##[1:3] (cpu_clock_run && !cpu_path_enable_n);
    endsequence
    property p_keep; $rose(host_req.select) |-> s_keep; endproperty
    a_keep: assert property (p_keep) else $error("cpu stopped early");
    property p_order; $fell(host_path_enable_n) |-> $past(cpu_path_enable_n); endproperty
    a_order: assert property (p_order) else $error("host path before cpu off");
    property p_lat;
        $rose(host_req.select) && host_req.addr[17:16] == 2'h0 |-> ##[RDY_MIN:RDY_MAX] host_ready;
    endproperty
    a_lat: assert property (p_lat) else $error("ready late");
    property p_susp; host_ready |-> !cpu_clock_run && cpu_path_enable_n; endproperty
    a_susp: assert property (p_susp) else $error("cpu runs in host access");
    property p_rel; $fell(host_ready) |-> $past(host_req.select, 2) == 1'b0; endproperty
    a_rel: assert property (p_rel) else $error("ready fell early");
    property p_rest; $fell(host_ready) |-> s_restore; endproperty
    a_rest: assert property (p_rest) else $error("cpu not restored");
    property p_own; cpu_clock_run |-> !cpu_path_enable_n && host_path_enable_n; endproperty
    a_own: assert property (p_own) else $error("two bus owners");
    property p_oe; !memory_write_enable_n |-> memory_output_enable_n; endproperty
    a_oe: assert property (p_oe) else $error("memory drives in write");
    property p_pwr;
        cpu_clock_run && $past(cpu_clock_run) && !$past(cpu_ctl.mem_select) |-> memory_chip_enable_n;
    endproperty
    a_pwr: assert property (p_pwr) else $error("chip enabled idle");
    property p_rd;
        cpu_clock_run && cpu_ctl.mem_select && !cpu_ctl.mem_write |-> ##2 regfile_write_b_en;
    endproperty
    a_rd: assert property (p_rd) else $error("read data missing");
endmodule

bind shm_host_access shm_host_access_properties #(.ACCESS_CYCLES(ACCESS_CYCLES)) i_props (
    .clock, .rst, .cpu_ctl, .host_req, .host_ready, .cpu_clock_run, .cpu_path_enable_n,
    .host_path_enable_n, .memory_chip_enable_n, .memory_output_enable_n,
    .memory_write_enable_n, .regfile_write_b_en
);

// ===== verif/shm_host_master.sv
// Host bus master model
module shm_host_master
    import shm_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        host_ready,
    input  wire logic [35:0] host_rdata,
    output shm_host_req_t    host_req,
    output logic [35:0]      host_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        host_req = '0;
        host_wdata = '0;
    end
    // One transfer, ok low when ready never came
    task automatic xfer(input logic wr, input logic [17:0] a, input logic [35:0] d,
                        output logic ok, output logic [35:0] rd);
        int n;
        ok = 1'b0;
        rd = '0;
        @(posedge clock) #1;
        host_req = '{1'b1, wr, a};
        host_wdata = d;
        for (n = 0; n < 40 && !ok; n++) begin
            @(posedge clock);
            ok = host_ready;
            rd = host_rdata;
        end
        #1;
        host_req.select = 1'b0;
        host_req.addr = ~a;
        host_wdata = ~d;
    endtask
endmodule

// ===== verif/shm_host_access_test.sv
// Self-checking bench for the shared memory host access block
module shm_host_access_test
    import shm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic          clock = 1'b0;
    logic          rst = 1'b1;
    shm_cpu_ctl_t  cpu_ctl = '0;
    shm_host_req_t host_req;
    logic [31:0]   regfile_port_a = '0;
    logic [35:0]   regfile_port_b = '0, memory_rdata = '0, host_wdata, host_rdata;
    logic [35:0]   regfile_write_b_data, memory_data_bus, seen_data;
    logic [13:0]   memory_address_bus, seen_addr, cnt_a = '0, cnt_b = '0;
    logic          regfile_write_b_en, host_rdata_oe, host_ready, cpu_clock_run;
    logic          cpu_path_enable_n, host_path_enable_n, memory_data_oe, memory_chip_enable_n;
    logic          memory_output_enable_n, memory_write_enable_n, memory_write_phase;
    logic          prev_rd = 1'b0, seen_rd_oe = 1'b0;
    int            errors = 0;
    int            total_checks = 0;

    shm_host_access i_shm_host_access (
        .clock, .rst, .cpu_ctl, .regfile_port_a, .regfile_port_b, .host_req, .host_wdata,
        .memory_rdata, .regfile_write_b_data, .regfile_write_b_en, .host_rdata,
        .host_rdata_oe, .host_ready, .cpu_clock_run, .cpu_path_enable_n, .host_path_enable_n,
        .memory_address_bus, .memory_data_bus, .memory_data_oe, .memory_chip_enable_n,
        .memory_output_enable_n, .memory_write_enable_n, .memory_write_phase
    );
    shm_host_master i_host (.clock, .host_ready, .host_rdata, .host_req, .host_wdata);

    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        if (!host_path_enable_n && !memory_chip_enable_n) seen_addr <= memory_address_bus;
        if (!host_path_enable_n && !memory_write_enable_n) seen_data <= memory_data_bus;
        if (!host_path_enable_n) seen_rd_oe <= host_rdata_oe;
    end

    function automatic logic [13:0] exp_addr(shm_src_t s, logic [31:0] a);
        case (s)
            SHM_SRC_CNT_A: return cnt_a;
            SHM_SRC_CNT_B: return cnt_b;
            default: return a[15:2];
        endcase
    endfunction
    function automatic logic [13:0] next_cnt(shm_cnt_op_t op, logic [13:0] v, logic [31:0] a);
        case (op)
            SHM_CNT_LOAD: return a[15:2];
            SHM_CNT_UP: return v + 14'h1;
            SHM_CNT_DOWN: return v - 14'h1;
            default: return v;
        endcase
    endfunction
    task automatic check(input string what, input logic [35:0] e, input logic [35:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cpu_step(input shm_cpu_ctl_t c, input logic [31:0] a);
        cpu_ctl = c;
        regfile_port_a = a;
        regfile_port_b = {4'h9, $urandom};
        memory_rdata = {$urandom, 4'h6};
        @(posedge clock) #1;
        check("ce_n", !c.mem_select, memory_chip_enable_n);
        check("we_n", !(c.mem_select && c.mem_write), memory_write_enable_n);
        check("data_oe", c.mem_select && c.mem_write, memory_data_oe);
        check("oe_n", !(c.mem_select && !c.mem_write), memory_output_enable_n);
        check("phase", c.mem_select && c.mem_write, memory_write_phase);
        if (c.mem_select) check("addr", exp_addr(c.addr_src, a), memory_address_bus);
        if (c.mem_select && c.mem_write) check("wdata", regfile_port_b, memory_data_bus);
        check("b_en", prev_rd, regfile_write_b_en);
        if (prev_rd) check("b_data", memory_rdata, regfile_write_b_data);
        prev_rd = c.mem_select && !c.mem_write;
        cnt_a = next_cnt(c.cnt_a_op, cnt_a, a);
        cnt_b = next_cnt(c.cnt_b_op, cnt_b, a);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        // Tests need about 150 cycles
        #20000;
        errors++;
        conclude();
    end
    initial begin
        shm_cpu_ctl_t c;
        logic ok;
        logic [35:0] rd, d;
        logic [17:0] ha;
        void'($urandom(76515));
        repeat (5) @(posedge clock);
        #1 rst = 1'b0;
        check("run", 1'b1, cpu_clock_run && !cpu_path_enable_n && host_path_enable_n);
        cpu_step('{1'b0, 1'b0, SHM_SRC_REGFILE, SHM_CNT_LOAD, SHM_CNT_LOAD}, 32'h1fc);
        cpu_step('{1'b1, 1'b0, SHM_SRC_CNT_A, SHM_CNT_UP, SHM_CNT_DOWN}, '0);
        cpu_step('{1'b1, 1'b1, SHM_SRC_CNT_A, SHM_CNT_HOLD, SHM_CNT_HOLD}, '0);
        repeat (60) begin
            c = 8'($urandom);
            if (c.addr_src == SHM_SRC_HOST) c.addr_src = SHM_SRC_CNT_B;
            cpu_step(c, $urandom);
        end
        cpu_step('0, '0);
        for (int i = 0; i < 4; i++) begin
            if (i != 1) ha = {(i == 2) ? 2'h1 : 2'h0, 14'($urandom), 2'h0};
            d = {$urandom, 4'ha};
            memory_rdata = {4'h3, $urandom};
            i_host.xfer(i != 1, ha, d, ok, rd);
            check("ready", i != 2, ok);
            if (i == 1) check("host_rdata", memory_rdata, rd);
            if (ok) check("host_addr", ha[15:2], seen_addr);
            if (ok && i != 1) check("host_data", d, seen_data);
            if (ok) check("rdata_oe", i == 1, seen_rd_oe);
            for (int n = 0; n < 20 && !cpu_clock_run; n++) @(posedge clock);
            #1 check("restored", 1'b1, cpu_clock_run && host_path_enable_n);
        end
        conclude();
    end
endmodule
